//--- design/daisy_chain_interrupt_logic.sv
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "daisy_chain_params.svh"

module daisy_chain_interrupt_logic (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Processor bus and chain
    input wire logic opcode_fetch_n_i,
    input wire logic read_strobe_n_i,
    input wire logic io_request_n_i,
    input wire logic ack_pin_n_i,
    input wire logic [7:0] data_i,
    input wire logic priority_in_i,
    input wire logic event_i,
    input wire logic service_done_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    output logic irq_o,
    output logic irq_oe_n_o,
    output logic priority_out_o
);

    daisy_chain_pkg::cpu_bus_t bus;
    daisy_chain_pkg::ret_state_t ret_state;
    daisy_chain_pkg::ret_state_t next_ret_state;
    daisy_chain_pkg::data_drive_t next_drive;

    logic [1:0] control;
    logic [7:0] vector;
    logic pending_flag;
    logic in_service_flag;
    logic ack_latched;
    logic vector_taken;
    logic wr_pend;
    logic [11:0] wr_addr;

    assign bus = '{opcode_fetch_n: opcode_fetch_n_i, read_strobe_n: read_strobe_n_i,
                   io_request_n: io_request_n_i, ack_pin_n: ack_pin_n_i, data: data_i};

    // Bus cycle decode
    wire irq_enabled = control[`CTRL_IRQ_ENABLE];
    wire ack_pin_mode = control[`CTRL_ACK_PIN_MODE];
    wire fetch_ack = !bus.opcode_fetch_n && bus.read_strobe_n;
    wire fetch_read = !bus.opcode_fetch_n && !bus.read_strobe_n;
    wire strobe_ack = fetch_ack && !bus.io_request_n;
    wire pin_ack = !bus.ack_pin_n && !bus.read_strobe_n;
    wire vector_window = ack_pin_mode ? pin_ack : strobe_ack;
    wire ack_cycle = ack_pin_mode ? !bus.ack_pin_n : fetch_ack;
    // Pending may not be set from acknowledge start until the vector is taken
    wire status_frozen = ack_cycle && !vector_taken;
    wire we_own = vector_window && ack_latched && priority_in_i;
    wire first_byte = fetch_read && bus.data == `RET_FIRST_BYTE && ret_state == daisy_chain_pkg::RET_IDLE;
    wire second_byte = fetch_read && bus.data == `RET_SECOND_BYTE &&
                       ret_state == daisy_chain_pkg::RET_GOT_FIRST;

    // Return opcode tracker; any fetched byte other than the second or a repeated first byte aborts the pair
    always_comb begin
        next_ret_state = ret_state;
        case (ret_state)
            daisy_chain_pkg::RET_IDLE: begin
                if (first_byte) next_ret_state = daisy_chain_pkg::RET_GOT_FIRST;
            end
            daisy_chain_pkg::RET_GOT_FIRST: begin
                if (!fetch_read) next_ret_state = daisy_chain_pkg::RET_GOT_FIRST;
                else if (second_byte) next_ret_state = daisy_chain_pkg::RET_WAIT_END;
                else if (bus.data != `RET_FIRST_BYTE) next_ret_state = daisy_chain_pkg::RET_WAIT_END;
            end
            daisy_chain_pkg::RET_WAIT_END: begin
                if (bus.opcode_fetch_n) next_ret_state = daisy_chain_pkg::RET_IDLE;
            end
            default: next_ret_state = daisy_chain_pkg::RET_IDLE;
        endcase
    end

    // Latch request ownership at acknowledge start, before io request
    wire ack_start = ack_cycle && !ack_latched && !vector_taken;
    wire owner_now = pending_flag && !in_service_flag && priority_in_i;

    // Interrupt flags
    wire sw_event = wr_pend && wr_addr == `REG_COMMAND && hwdata_i[`CMD_RAISE_EVENT];
    wire sw_done = wr_pend && wr_addr == `REG_COMMAND && hwdata_i[`CMD_SERVICE_DONE];
    wire sw_clr_ius = wr_pend && wr_addr == `REG_COMMAND && hwdata_i[`CMD_CLEAR_IN_SERVICE];
    wire set_pending = (event_i || sw_event) && irq_enabled && !status_frozen;
    wire clr_pending = service_done_i || sw_done;
    wire set_ius = we_own && !in_service_flag;
    // Decoded return clears in-service only with chain input high
    wire ret_clear = !ack_pin_mode && second_byte && priority_in_i;
    wire clr_ius = ret_clear || (ack_pin_mode && sw_clr_ius);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pending_flag <= 1'b0;
            in_service_flag <= 1'b0;
            ack_latched <= 1'b0;
            vector_taken <= 1'b0;
            ret_state <= daisy_chain_pkg::RET_IDLE;
        end else begin
            // Set wins over a simultaneous clear
            pending_flag <= set_pending | (pending_flag & ~clr_pending);
            in_service_flag <= set_ius | (in_service_flag & ~clr_ius);
            ack_latched <= ack_start ? owner_now : (ack_cycle ? ack_latched : 1'b0);
            vector_taken <= ack_cycle && (vector_taken || we_own);
            ret_state <= next_ret_state;
        end
    end

    // Chain outputs: first return byte opens chain unless in service
    wire chain_block = pending_flag || in_service_flag || ack_latched;
    wire ret_window = ret_state == daisy_chain_pkg::RET_GOT_FIRST || first_byte;
    wire next_prio = priority_in_i && (in_service_flag ? 1'b0 : (ret_window ? 1'b1 : !chain_block));
    // Request withdrawn once acknowledged or in service
    wire next_irq = pending_flag && !in_service_flag && !ack_latched && priority_in_i;

    always_comb begin
        next_drive.data = vector;
        next_drive.oe_n = !we_own;
    end

    // Registered pin drive; open-drain request low when asserted
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            priority_out_o <= 1'b0;
            irq_o <= 1'b0;
            irq_oe_n_o <= 1'b1;
            data_o <= 8'h00;
            data_oe_n_o <= 1'b1;
        end else begin
            priority_out_o <= next_prio;
            irq_o <= 1'b0;
            irq_oe_n_o <= !next_irq;
            data_o <= next_drive.data;
            data_oe_n_o <= next_drive.oe_n;
        end
    end

    // AHB-Lite slave: zero wait states, writes commit in data phase
    wire addr_valid = hsel_i && htrans_i[1] && hready_i;
    wire [31:0] status_word = {27'h0000000, ret_state == daisy_chain_pkg::RET_GOT_FIRST,
                               priority_out_o, priority_in_i, in_service_flag, pending_flag};
    wire [31:0] next_rdata = haddr_i == `REG_CONTROL ? {30'h00000000, control} :
                             haddr_i == `REG_VECTOR ? {24'h000000, vector} :
                             haddr_i == `REG_STATUS ? status_word : 32'h00000000;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata_o <= 32'h00000000;
        end else begin
            wr_pend <= addr_valid && hwrite_i;
            wr_addr <= haddr_i;
            hrdata_o <= (addr_valid && !hwrite_i) ? next_rdata : 32'h00000000;
        end
    end

    // Software control and vector registers
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            control <= `CONTROL_RESET;
            vector <= `VECTOR_RESET;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (wr_pend && wr_addr == `REG_CONTROL) control <= hwdata_i[1:0];
            if (wr_pend && wr_addr == `REG_VECTOR) vector <= hwdata_i[7:0];
        end
    end

endmodule : daisy_chain_interrupt_logic

//--- design/daisy_chain_params.svh
`ifndef DAISY_CHAIN_PARAMS_SVH
`define DAISY_CHAIN_PARAMS_SVH

// AHB register byte offsets
`define REG_CONTROL 12'h000
`define REG_VECTOR 12'h004
`define REG_STATUS 12'h008
`define REG_COMMAND 12'h00c

// Control register fields
`define CTRL_IRQ_ENABLE 0
`define CTRL_ACK_PIN_MODE 1

// Command register fields, write one to act
`define CMD_RAISE_EVENT 0
`define CMD_SERVICE_DONE 1
`define CMD_CLEAR_IN_SERVICE 2

// Status register fields
`define STAT_PENDING 0
`define STAT_IN_SERVICE 1
`define STAT_PRIORITY_IN 2
`define STAT_PRIORITY_OUT 3
`define STAT_FIRST_BYTE_SEEN 4

// Reset values
`define CONTROL_RESET 2'h0
`define VECTOR_RESET 8'h00

// Return sequence opcode bytes
`define RET_FIRST_BYTE 8'hed
`define RET_SECOND_BYTE 8'h4d

`endif

//--- design/daisy_chain_pkg.sv
package daisy_chain_pkg;

    // Processor bus strobes as seen by one chain device
    typedef struct packed {
        logic opcode_fetch_n;
        logic read_strobe_n;
        logic io_request_n;
        logic ack_pin_n;
        logic [7:0] data;
    } cpu_bus_t;

    // Return-sequence decoder states
    typedef enum logic [2:0] {
        RET_IDLE = 3'b001,
        RET_GOT_FIRST = 3'b010,
        RET_WAIT_END = 3'b100
    } ret_state_t;

    // Data bus drive toward the processor
    typedef struct packed {
        logic [7:0] data;
        logic oe_n;
    } data_drive_t;

endpackage : daisy_chain_pkg

//--- test/cpu_bus_model.sv
`timescale 1ns/1ps
// Processor side of the bus plus its data buffer, as one chain device sees it
module cpu_bus_model (
    input wire logic clk_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_n_i,
    output logic fetch_n_o = 1'h1,
    output logic rd_n_o = 1'h1,
    output logic ioreq_n_o = 1'h1,
    output logic ack_n_o = 1'h1,
    output logic [7:0] bus_o
);
    logic [7:0] cpu_data = 8'h00;
    // Buffer turns toward the processor only while a vector is driven
    assign bus_o = dev_oe_n_i ? cpu_data : dev_data_i;
    // Opcode fetch; a released bus shows the inverse, never the stale byte
    task fetch(input logic [7:0] b);
        // One released cycle always separates two return bytes
        @(posedge clk_i);
        fetch_n_o <= 1'h0;
        rd_n_o <= 1'h0;
        cpu_data <= b;
        repeat (2) @(posedge clk_i);
        fetch_n_o <= 1'h1;
        rd_n_o <= 1'h1;
        cpu_data <= ~b;
    endtask : fetch
    // Acknowledge: fetch without read, io request after two wait states
    // Pin mode: system logic adds ack pin and read strobe to the same cycle
    task ack(input logic pin, input int extra, output logic [7:0] v);
        int cnt;
        @(posedge clk_i);
        fetch_n_o <= 1'h0;
        ack_n_o <= !pin;
        repeat (2) @(posedge clk_i);
        // Added wait states: counter preset to five minus added, io request held back
        for (cnt = 5 - extra; cnt < 5; cnt++) @(posedge clk_i);
        ioreq_n_o <= 1'h0;
        rd_n_o <= !pin;
        repeat (2) @(posedge clk_i);
        v = bus_o;
        fetch_n_o <= 1'h1;
        ioreq_n_o <= 1'h1;
        ack_n_o <= 1'h1;
        rd_n_o <= 1'h1;
    endtask : ack
endmodule : cpu_bus_model

//--- test/daisy_chain_interrupt_logic_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end
module daisy_chain_interrupt_logic_tb;
    logic ref_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic hsel_i = 1'h0;
    logic hwrite_i = 1'h0;
    logic priority_in_i = 1'h1;
    logic event_i = 1'h0;
    logic service_done_i = 1'h0;
    logic [11:0] haddr_i = 12'h000;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic [31:0] rd;
    logic [7:0] data_o;
    logic [7:0] vec;
    logic hreadyout_o, hresp_o, data_oe_n_o, irq_o, irq_oe_n_o, priority_out_o;
    wire logic opcode_fetch_n_i, read_strobe_n_i, io_request_n_i, ack_pin_n_i;
    wire logic [7:0] data_i;
    wire logic hready_i = hreadyout_o;
    wire logic [2:0] hsize_i = 3'h2;
    int num_errors = 0;
    int samples_checked = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    daisy_chain_interrupt_logic dut (.*);
    cpu_bus_model cpu (.clk_i(ref_clk_i), .dev_data_i(data_o), .dev_oe_n_i(data_oe_n_o),
        .fetch_n_o(opcode_fetch_n_i), .rd_n_o(read_strobe_n_i), .ioreq_n_o(io_request_n_i),
        .ack_n_o(ack_pin_n_i), .bus_o(data_i));
    // Single word transfer; no latency assumed, both phases wait on hready
    task ahb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge ref_clk_i);
        hsel_i <= 1'h1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        do @(posedge ref_clk_i); while (hready_i !== 1'h1);
        htrans_i <= 2'h0;
        hsel_i <= 1'h0;
        hwdata_i <= wd;
        do @(posedge ref_clk_i); while (hready_i !== 1'h1);
        rd = hrdata_o;
    endtask : ahb
    // Pending and in-service bits of the status word
    task stat(input logic [1:0] e);
        ahb(12'h008, 1'h0, 32'h0);
        `CHK("status", e, rd[1:0])
    endtask : stat
    task tally_and_finish;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'h0;
        repeat (2) @(posedge ref_clk_i);
        #1 `CHK("prio_out", 1'h1, priority_out_o)
        ahb(12'h00c, 1'h1, 32'h1);
        stat(2'h0);
        ahb(12'h004, 1'h1, 32'h5a);
        ahb(12'h000, 1'h1, 32'h1);
        @(posedge ref_clk_i) event_i <= 1'h1;
        @(posedge ref_clk_i) event_i <= 1'h0;
        stat(2'h1);
        #1 `CHK("irq_oe_n", 1'h0, irq_oe_n_o)
        `CHK("prio_out", 1'h0, priority_out_o)
        cpu.fetch(8'hed);
        #1 `CHK("prio_out", 1'h1, priority_out_o)
        cpu.fetch(8'h4d);
        #1 `CHK("prio_out", 1'h0, priority_out_o)
        cpu.ack(1'h0, 0, vec);
        `CHK("vector", 8'h5a, vec)
        #1 `CHK("irq_oe_n", 1'h1, irq_oe_n_o)
        stat(2'h3);
        @(posedge ref_clk_i) service_done_i <= 1'h1;
        @(posedge ref_clk_i) service_done_i <= 1'h0;
        stat(2'h2);
        priority_in_i <= 1'h0;
        cpu.fetch(8'hed);
        cpu.fetch(8'h4d);
        stat(2'h2);
        priority_in_i <= 1'h1;
        cpu.fetch(8'hed);
        #1 `CHK("prio_out", 1'h0, priority_out_o)
        cpu.fetch(8'h4d);
        #1 `CHK("prio_out", 1'h1, priority_out_o)
        stat(2'h0);
        `CHK("irq_level", 1'h0, irq_o)
        // Ack-pin mode with two added wait states; return bytes must not clear
        ahb(12'h000, 1'h1, 32'h3);
        ahb(12'h00c, 1'h1, 32'h1);
        cpu.ack(1'h1, 2, vec);
        `CHK("pin_vector", 8'h5a, vec)
        stat(2'h3);
        ahb(12'h00c, 1'h1, 32'h2);
        cpu.fetch(8'hed);
        cpu.fetch(8'h4d);
        stat(2'h2);
        ahb(12'h00c, 1'h1, 32'h4);
        stat(2'h0);
        #1 `CHK("prio_out", 1'h1, priority_out_o)
        ahb(12'h0f0, 1'h0, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        tally_and_finish;
    end
    // Watchdog well past the hundred or so cycles the tests need
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        num_errors++;
        tally_and_finish;
    end
endmodule : daisy_chain_interrupt_logic_tb

//--- test/daisy_chain_props.sv
`timescale 1ns/1ps
module daisy_chain_props (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic opcode_fetch_n_i,
    input wire logic read_strobe_n_i,
    input wire logic io_request_n_i,
    input wire logic [7:0] data_i,
    input wire logic priority_in_i,
    input wire logic data_oe_n_o,
    input wire logic irq_oe_n_o,
    input wire logic priority_out_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Chain and request relations, one cycle of output latency
    property p_req_gate; !irq_oe_n_o |-> $past(priority_in_i); endproperty
    a_req_gate: assert property (p_req_gate) else $error("irq without priority_in");
    property p_req_blocks; $fell(irq_oe_n_o) |-> !priority_out_o; endproperty
    a_req_blocks: assert property (p_req_blocks) else $error("request left chain open");
    property p_vec_start; $fell(data_oe_n_o) |-> $past(!opcode_fetch_n_i && !io_request_n_i && priority_in_i);
    endproperty
    a_vec_start: assert property (p_vec_start) else $error("vector outside acknowledge");
    property p_vec_end; !data_oe_n_o |-> $past(!io_request_n_i) || $past(!io_request_n_i, 2); endproperty
    a_vec_end: assert property (p_vec_end) else $error("vector held too long");
    property p_serv_block; $fell(data_oe_n_o) |-> ##1 !priority_out_o [*2]; endproperty
    a_serv_block: assert property (p_serv_block) else $error("in service chain open");
    property p_irq_drop; $fell(data_oe_n_o) |-> irq_oe_n_o; endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq kept after acknowledge");
    // Hazard: a pending device must still pass the first return byte down
    property p_ed_release;
        !opcode_fetch_n_i && !read_strobe_n_i && data_i == 8'hed && priority_in_i && !irq_oe_n_o |=> priority_out_o;
    endproperty
    a_ed_release: assert property (p_ed_release) else $error("chain not released on first byte");
    property p_out_gate; priority_out_o |-> $past(priority_in_i); endproperty
    a_out_gate: assert property (p_out_gate) else $error("priority_out without priority_in");
    property p_bus_ok; hreadyout_o && !hresp_o; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
    cover property ($fell(data_oe_n_o));
    cover property ($rose(priority_out_o));
    cover property ($fell(irq_oe_n_o));
endmodule : daisy_chain_props
bind daisy_chain_interrupt_logic daisy_chain_props chk (.*);
